// ### design/hmpc_pkg.sv
/*
  Shared constants for the haptic mode and power control block: mode codes,
  power states, reset values and timing counts.
  Assumes a core clock of 125 MHz; the watchdog count is derived from it.
*/
package hmpc_pkg;

  // ************************************************************
  // mode field codes
  // ************************************************************
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_INTERNAL = 3'h0;
  localparam logic [2:0] MODE_EXT_EDGE = 3'h1;
  localparam logic [2:0] MODE_EXT_LEVEL = 3'h2;
  localparam logic [2:0] MODE_INPUT_DRIVE = 3'h3;
  localparam logic [2:0] MODE_REALTIME = 3'h5;
  localparam logic [2:0] MODE_DIAG = 3'h6;
  localparam logic [2:0] MODE_CALIB = 3'h7;

  // ************************************************************
  // register locations and reset values
  // ************************************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h01;
  localparam logic [7:0] ADDR_SEQ_FIRST = 8'h04;
  localparam logic [7:0] ADDR_SEQ_LAST = 8'h0B;
  localparam logic [7:0] ADDR_FIRE = 8'h0C;
  localparam logic [7:0] FIRE_WRITE_VALUE = 8'h01;
  localparam logic RST_STANDBY = 1'b1;
  localparam logic [2:0] RST_MODE = MODE_INTERNAL;
  localparam logic RST_INPUT_PWM = 1'b0;
  localparam logic RST_FIRE = 1'b0;

  // ************************************************************
  // power states, gray along shutdown-standby-ready
  // ************************************************************
  typedef enum logic [1:0] {
    PWR_SHUTDOWN = 2'h0,
    PWR_STANDBY = 2'h1,
    PWR_READY = 2'h3,
    PWR_RESET = 2'h2
  } hmpc_pwr_t;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam longint WDOG_TIME_PS = 64'd4330000000;
  localparam int WDOG_CYCLES = int'((WDOG_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int WDOG_CNT_W = 20;
  localparam int DEVRST_CYCLES = 4;
  localparam int DEVRST_CNT_W = 3;

endpackage

// ### design/hmpc_power_ctrl.sv
/*
  Mode, firing, power-state, watchdog and protection control of a haptic
  actuator driver. Register fields arrive as plain write strobes and values
  from the register front end; status leaves as plain outputs.
  Assumes: protection comparators, pins and the link-side busy/byte signals
  are asynchronous to clk; sequencer done comes from clk logic; the serial
  protocol engine runs on linkClk and honours protoRecover as a reset.
*/
`timescale 1ns/1ps
`default_nettype none

module hmpc_power_ctrl #(
  parameter int WDOG_CYCLES = hmpc_pkg::WDOG_CYCLES,
  parameter int DEVRST_CYCLES = hmpc_pkg::DEVRST_CYCLES
) (
  input wire logic clk, // core clock
  input wire logic srst, // synchronous reset, active high
  input wire logic linkClk, // serial protocol clock
  input wire logic linkBusy, // transaction in progress, link domain
  input wire logic linkByteDone, // byte finished pulse, link domain
  input wire logic enablePin, // enable pin, asynchronous
  input wire logic trigger_input_pin, // external trigger pin, asynchronous
  input wire logic overTempIn, // thermal comparator, asynchronous
  input wire logic outShortIn, // output impedance too low, asynchronous
  input wire logic regShortIn, // regulator short, asynchronous
  input wire logic brownoutIn, // brownout comparator, asynchronous
  input wire logic ctlWr, // write strobe for mode register
  input wire logic ctlWrStandby, // standby bit value
  input wire logic ctlWrDevReset, // software reset bit value
  input wire logic [2:0] ctlWrMode, // mode field value
  input wire logic ctlWrInputPwm, // input selection: 1 pulse-width, 0 analog
  input wire logic fireWr, // write strobe for firing register
  input wire logic [7:0] fireWrData, // firing register write data
  input wire logic seqDone, // process finished pulse
  output logic regAccessEn, // register reads and writes permitted
  output logic standby, // standby bit
  output logic devReset, // software reset bit
  output logic [2:0] mode, // mode field
  output logic inputPwm, // input selection bit
  output logic fireBit, // stored firing bit
  output logic goSignal, // internal firing signal
  output logic driveEnable, // output stage allowed to drive
  output logic shortCheckEn, // output short monitoring enabled
  output logic overTempFlag, // over-temperature status
  output logic output_short_flag, // overcurrent status
  output logic realtime_register_playback, // realtime mode selected
  output logic diagRun, // diagnostics process running
  output logic calibRun, // calibration process running
  output logic protoRecover, // protocol engine reset request
  output logic [1:0] powerState // power state code
);

  // ************************************************************
  // parameter checks
  // ************************************************************
  initial begin
    if (WDOG_CYCLES < 2 || WDOG_CYCLES >= (1 << hmpc_pkg::WDOG_CNT_W)) begin
      $error("watchdog count out of range");
    end
    if (DEVRST_CYCLES < 1 || DEVRST_CYCLES >= (1 << hmpc_pkg::DEVRST_CNT_W)) begin
      $error("reset length out of range");
    end
  end

  // ************************************************************
  // link domain
  // ************************************************************
  logic linkTgl_q = 1'b0; // no reset: link clock may be stopped

  // byte-activity toggle on the link clock; busy is a level and is
  // synchronised directly, since a hung frame stops the link clock
  always_ff @(posedge linkClk) begin
    if (linkByteDone) begin
      linkTgl_q <= ~linkTgl_q;
    end
  end

  // ************************************************************
  // synchronisers
  // ************************************************************
  logic [6:0] syncA_q;
  logic [6:0] syncB_q;
  logic tglA_q;
  logic tglB_q;
  logic [7:0] asyncIn;
  logic actTglPrev_q;
  logic trigPrev_q;
  logic enS;
  logic trigS;
  logic hotS;
  logic shortS;
  logic regShortS;
  logic brownS;
  logic busyS;
  logic actTglS;

  assign asyncIn = {linkTgl_q, linkBusy, brownoutIn, regShortIn, outShortIn,
                    overTempIn, trigger_input_pin, enablePin};

  // two flops per asynchronous level; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      syncA_q <= 7'h00;
      syncB_q <= 7'h00;
    end else begin
      syncA_q <= asyncIn[6:0];
      syncB_q <= syncA_q;
    end
  end

  // activity toggle crossing, third flop for change detect
  always_ff @(posedge clk) begin
    if (srst) begin
      tglA_q <= 1'b0;
      tglB_q <= 1'b0;
      actTglPrev_q <= 1'b0;
      trigPrev_q <= 1'b0;
    end else begin
      tglA_q <= asyncIn[7];
      tglB_q <= tglA_q;
      actTglPrev_q <= tglB_q;
      trigPrev_q <= syncB_q[1];
    end
  end

  assign enS = syncB_q[0];
  assign trigS = syncB_q[1];
  assign hotS = syncB_q[2];
  assign shortS = syncB_q[3];
  assign regShortS = syncB_q[4];
  assign brownS = syncB_q[5];
  assign busyS = syncB_q[6];
  assign actTglS = tglB_q;

  // ************************************************************
  // internal reset sources
  // ************************************************************
  logic [hmpc_pkg::DEVRST_CNT_W-1:0] devRstCnt_q;
  logic devReset_q;
  logic hwRst;
  logic intRst;
  logic writeOk;
  logic devRstReq;

  assign writeOk = enS;
  assign hwRst = srst | regShortS | brownS;
  assign devRstReq = ctlWr && writeOk && ctlWrDevReset;
  assign intRst = hwRst | devReset_q | devRstReq;

  // software reset bit holds the logic in reset for a few cycles
  always_ff @(posedge clk) begin
    if (hwRst) begin
      devReset_q <= 1'b0;
      devRstCnt_q <= '0;
    end else if (devReset_q) begin
      devRstCnt_q <= devRstCnt_q - 1'b1;
      if (devRstCnt_q == 1) begin
        devReset_q <= 1'b0;
      end
    end else if (ctlWr && writeOk && ctlWrDevReset) begin
      devReset_q <= 1'b1;
      devRstCnt_q <= DEVRST_CYCLES[hmpc_pkg::DEVRST_CNT_W-1:0];
    end
  end

  // ************************************************************
  // mode register fields
  // ************************************************************
  logic standby_q;
  logic [2:0] mode_q;
  logic inputPwm_q;

  // host writes land only with the enable pin high
  always_ff @(posedge clk) begin
    if (intRst) begin
      standby_q <= hmpc_pkg::RST_STANDBY;
      mode_q <= hmpc_pkg::RST_MODE;
      inputPwm_q <= hmpc_pkg::RST_INPUT_PWM;
    end else if (ctlWr && writeOk && !ctlWrDevReset) begin
      standby_q <= ctlWrStandby;
      mode_q <= ctlWrMode;
      inputPwm_q <= ctlWrInputPwm;
    end
  end

  // ************************************************************
  // power state
  // ************************************************************
  hmpc_pkg::hmpc_pwr_t pwr_q;
  logic ready;

  // shutdown on enable low keeps the mode register fields as they are
  always_ff @(posedge clk) begin
    if (intRst) begin
      pwr_q <= hmpc_pkg::PWR_RESET;
    end else begin
      case (pwr_q)
        hmpc_pkg::PWR_RESET: begin
          pwr_q <= enS ? hmpc_pkg::PWR_STANDBY : hmpc_pkg::PWR_SHUTDOWN;
        end
        default: begin
          if (!enS) begin
            pwr_q <= hmpc_pkg::PWR_SHUTDOWN;
          end else if (standby_q) begin
            pwr_q <= hmpc_pkg::PWR_STANDBY;
          end else begin
            pwr_q <= hmpc_pkg::PWR_READY;
          end
        end
      endcase
    end
  end

  // standby acts at once, not one state update later
  assign ready = (pwr_q == hmpc_pkg::PWR_READY) && enS && !standby_q;

  // ************************************************************
  // mode decode
  // ************************************************************
  function automatic logic isContinuous(input logic [2:0] m, input logic pwm);
    isContinuous = (m == hmpc_pkg::MODE_REALTIME) ||
                   ((m == hmpc_pkg::MODE_INPUT_DRIVE) && pwm);
  endfunction

  logic contMode;
  logic trigRise;
  logic hostFireSet;
  logic hostFireClr;

  assign contMode = isContinuous(mode_q, inputPwm_q);
  assign trigRise = trigS && !trigPrev_q;
  assign hostFireSet = fireWr && writeOk && (fireWrData == hmpc_pkg::FIRE_WRITE_VALUE);
  assign hostFireClr = fireWr && writeOk && !fireWrData[0];

  // ************************************************************
  // short handling
  // ************************************************************
  logic shortFlag_q;
  logic shortLock_q;
  logic procRun;
  logic shortHit;
  logic fireBit_q;
  logic goSignal_q;

  assign procRun = (fireBit_q || contMode) && ready && !devReset_q;
  assign shortHit = shortS && goSignal_q;

  // flag stays while the short persists; lock waits for a mode change
  always_ff @(posedge clk) begin
    if (intRst) begin
      shortFlag_q <= 1'b0;
      shortLock_q <= 1'b0;
    end else begin
      if (shortHit) begin
        shortFlag_q <= 1'b1;
      end else if (!shortS) begin
        shortFlag_q <= 1'b0;
      end
      if (shortHit) begin
        shortLock_q <= 1'b1;
      end else if (ctlWr && writeOk && (ctlWrMode != mode_q) && !shortS) begin
        shortLock_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // firing bit
  // ************************************************************
  // per-mode source of the firing bit; host set wins over done
  always_ff @(posedge clk) begin
    if (intRst) begin
      fireBit_q <= hmpc_pkg::RST_FIRE;
    end else if (standby_q || shortHit) begin
      fireBit_q <= 1'b0;
    end else begin
      case (mode_q)
        hmpc_pkg::MODE_EXT_EDGE: begin
          if (trigRise) begin
            fireBit_q <= ~fireBit_q;
          end else if (hostFireClr || seqDone) begin
            fireBit_q <= 1'b0;
          end
        end
        hmpc_pkg::MODE_EXT_LEVEL: begin
          fireBit_q <= trigS;
        end
        default: begin
          if (hostFireSet) begin
            fireBit_q <= 1'b1;
          end else if (hostFireClr) begin
            fireBit_q <= 1'b0;
          end else if (seqDone) begin
            fireBit_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // firing signal and drive gating
  // ************************************************************
  logic goNow;
  logic driveEn_q;
  logic overTemp_q;

  assign goNow = procRun && !shortLock_q;

  // thermal flag follows the sensor; drive dropped while hot or shorted
  always_ff @(posedge clk) begin
    if (intRst) begin
      overTemp_q <= 1'b0;
      goSignal_q <= 1'b0;
      driveEn_q <= 1'b0;
    end else begin
      overTemp_q <= hotS;
      goSignal_q <= goNow;
      driveEn_q <= goNow && !hotS && !shortS;
    end
  end

  // ************************************************************
  // bus hang watchdog
  // ************************************************************
  logic [hmpc_pkg::WDOG_CNT_W-1:0] wdogCnt_q;
  logic recover_q;
  logic activity;

  assign activity = actTglS ^ actTglPrev_q;

  // counts while a transaction is open and silent, except in standby
  always_ff @(posedge clk) begin
    if (intRst) begin
      wdogCnt_q <= '0;
      recover_q <= 1'b0;
    end else if (recover_q) begin
      wdogCnt_q <= '0;
      if (!busyS) begin
        recover_q <= 1'b0;
      end
    end else if (!busyS || activity || standby_q) begin
      wdogCnt_q <= '0;
    end else if (wdogCnt_q == hmpc_pkg::WDOG_CNT_W'(WDOG_CYCLES - 1)) begin
      recover_q <= 1'b1;
      wdogCnt_q <= '0;
    end else begin
      wdogCnt_q <= wdogCnt_q + 1'b1;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign regAccessEn = writeOk;
  assign standby = standby_q;
  assign devReset = devReset_q;
  assign mode = mode_q;
  assign inputPwm = inputPwm_q;
  assign fireBit = fireBit_q;
  assign goSignal = goSignal_q;
  assign driveEnable = driveEn_q;
  assign shortCheckEn = goSignal_q;
  assign overTempFlag = overTemp_q;
  assign output_short_flag = shortFlag_q;
  assign realtime_register_playback = (mode_q == hmpc_pkg::MODE_REALTIME);
  assign diagRun = goSignal_q && (mode_q == hmpc_pkg::MODE_DIAG);
  assign calibRun = goSignal_q && (mode_q == hmpc_pkg::MODE_CALIB);
  assign protoRecover = recover_q;
  assign powerState = pwr_q;

endmodule

`default_nettype wire

// ### testbench/hmpc_power_ctrl_monitor.sv
/*
  Concurrent checks on the ports of the mode and power control block.
  Assumes one core clock domain; bound onto every instance of the block.
*/
`timescale 1ns/1ps
`default_nettype none

module hmpc_power_ctrl_monitor #(
  parameter int WDOG_CYCLES = 50,
  parameter int DEVRST_CYCLES = 4
) (
  input wire logic clk, // core clock
  input wire logic srst, // sync reset
  input wire logic linkBusy, // transaction open
  input wire logic ctlWr, // mode write strobe
  input wire logic fireWr, // firing write strobe
  input wire logic seqDone, // process done
  input wire logic regAccessEn, // access allowed
  input wire logic standby, // standby bit
  input wire logic devReset, // soft reset bit
  input wire logic [2:0] mode, // mode field
  input wire logic inputPwm, // input select
  input wire logic fireBit, // firing bit
  input wire logic goSignal, // firing signal
  input wire logic driveEnable, // drive allowed
  input wire logic shortCheckEn, // short monitor on
  input wire logic overTempFlag, // hot flag
  input wire logic output_short_flag, // short flag
  input wire logic protoRecover // protocol reset
);
  logic [19:0] busyCnt_q;
  logic [3:0] rstLen_q;

  // ********
  // helper counters
  // ********
  // open transaction time, paused in standby
  always_ff @(posedge clk) begin
    if (srst || !linkBusy) begin
      busyCnt_q <= '0;
    end else if (!standby) begin
      busyCnt_q <= busyCnt_q + 20'h00001;
    end
  end

  // length of the soft reset pulse
  always_ff @(posedge clk) begin
    if (srst || !devReset) begin
      rstLen_q <= '0;
    end else begin
      rstLen_q <= rstLen_q + 4'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // ********
  // assertions
  // ********
  rst_dflt_a: assert property ($fell(srst) |-> standby && mode == 3'h0 && !fireBit)
    else $error("fields not at defaults after reset");
  standby_go_a: assert property (standby |=> !goSignal)
    else $error("firing signal alive in standby");
  go_cause_a: assert property (
    goSignal |-> $past(fireBit || mode == 3'h5 || (mode == 3'h3 && inputPwm)))
    else $error("firing signal without cause");
  off_go_a: assert property (!regAccessEn |=> !goSignal)
    else $error("firing signal while disabled");
  off_write_a: assert property (!regAccessEn && ctlWr |=> $stable(mode) && $stable(standby))
    else $error("write taken while disabled");
  fire_held_a: assert property (
    fireBit && mode == 3'h0 && !standby && !fireWr && !seqDone && !ctlWr |=> fireBit)
    else $error("firing bit dropped early");
  short_go_a: assert property (output_short_flag |=> !goSignal)
    else $error("drive kept during short");
  short_run_a: assert property ($rose(output_short_flag) |-> $past(shortCheckEn))
    else $error("short flagged while idle");
  hot_drive_a: assert property ($rose(overTempFlag) |-> !driveEnable)
    else $error("drive kept while hot");
  sreset_len_a: assert property ($fell(devReset) |-> int'(rstLen_q) == DEVRST_CYCLES)
    else $error("soft reset length wrong");
  sreset_dflt_a: assert property (devReset |-> standby && mode == 3'h0 && !fireBit)
    else $error("fields not default in soft reset");
  wdog_sleep_a: assert property (standby |=> !$rose(protoRecover))
    else $error("watchdog fired in standby");
  wdog_time_a: assert property ($rose(protoRecover) |-> busyCnt_q >= 20'(WDOG_CYCLES))
    else $error("watchdog fired early");

  cover property ($rose(goSignal));
  cover property ($rose(protoRecover));
  cover property ($rose(output_short_flag));
  cover property ($fell(devReset));
endmodule

bind hmpc_power_ctrl hmpc_power_ctrl_monitor #(
  .WDOG_CYCLES(WDOG_CYCLES),
  .DEVRST_CYCLES(DEVRST_CYCLES)
) i_mon (.clk(clk), .srst(srst), .linkBusy(linkBusy), .ctlWr(ctlWr), .fireWr(fireWr),
  .seqDone(seqDone), .regAccessEn(regAccessEn), .standby(standby), .devReset(devReset),
  .mode(mode), .inputPwm(inputPwm), .fireBit(fireBit), .goSignal(goSignal),
  .driveEnable(driveEnable), .shortCheckEn(shortCheckEn), .overTempFlag(overTempFlag),
  .output_short_flag(output_short_flag), .protoRecover(protoRecover));

`default_nettype wire

// ### testbench/hmpc_link_host.sv
/*
  Behavioural far side of the serial link: frames with byte pulses, or a
  frame that hangs with its clock stopped until the protocol is reset.
  Assumes protoRecover comes from the block under test.
*/
`timescale 1ns/1ps
`default_nettype none

module hmpc_link_host (
  output logic linkClk, // link clock, runs only in frames
  output logic linkBusy, // transaction open
  output logic linkByteDone, // byte finished pulse
  input wire logic protoRecover // protocol reset request
);
  initial begin
    linkClk = 1'b0;
    linkBusy = 1'b0;
    linkByteDone = 1'b0;
  end

  // one 12 ns link cycle, byte pulse changed just after the rise
  task automatic tick(input logic bd);
    #6 linkClk = 1'b1;
    #1 linkByteDone = bd;
    #5 linkClk = 1'b0;
  endtask

  // frame of nb bytes, or a hang that waits for recovery
  task automatic frame(input int nb, input logic hang);
    #3 linkBusy = 1'b1;
    if (hang) begin
      wait (protoRecover === 1'b1);
    end else begin
      for (int b = 0; b < nb * 9; b++) tick(b % 9 == 8);
      tick(1'b0);
    end
    #2 linkBusy = 1'b0;
  endtask
endmodule

`default_nettype wire

// ### testbench/tb_haptic_mode_power_control.sv
/*
  Self-checking bench for the mode and power control block: strobes, pins
  and fault comparators from the bench, link side from the partner model.
  Assumes the monitor is bound in and a short watchdog count.
*/
`timescale 1ns/1ps
`default_nettype none

`define CMP(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb_haptic_mode_power_control;
  localparam int SB = 0, DV = 1, MD = 2, FB = 6, GO = 7, DE = 8, OT = 10, OS = 11;
  localparam int RT = 12, DG = 13, CB = 14, PR = 15, PS = 16, RA = 18, IP = 5, SC = 9;
  typedef struct {string nm; int lsb; int w; logic [3:0] v;} hmpc_note_t;
  logic clk, srst, linkClk, linkBusy, linkByteDone, enablePin, trigger_input_pin;
  logic overTempIn, outShortIn, regShortIn, brownoutIn, ctlWr, ctlWrStandby;
  logic ctlWrDevReset, ctlWrInputPwm, fireWr, seqDone, pw;
  logic [2:0] ctlWrMode, mode;
  logic [7:0] fireWrData;
  logic regAccessEn, standby, devReset, inputPwm, fireBit, goSignal, driveEnable;
  logic shortCheckEn, overTempFlag, output_short_flag, realtime_register_playback;
  logic diagRun, calibRun, protoRecover;
  logic [1:0] powerState;
  logic [18:0] obs;
  int err_total = 0, total_checks = 0, cycles = 0;
  logic [2:0] codes[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  hmpc_note_t notes[$];
  event look;

  assign obs = {regAccessEn, powerState, protoRecover, calibRun, diagRun,
    realtime_register_playback, output_short_flag, overTempFlag, shortCheckEn,
    driveEnable, goSignal, fireBit, inputPwm, mode, devReset, standby};

  hmpc_power_ctrl #(.WDOG_CYCLES(50), .DEVRST_CYCLES(4)) i_dut (.clk(clk), .srst(srst),
    .linkClk(linkClk), .linkBusy(linkBusy), .linkByteDone(linkByteDone),
    .enablePin(enablePin), .trigger_input_pin(trigger_input_pin), .overTempIn(overTempIn),
    .outShortIn(outShortIn), .regShortIn(regShortIn), .brownoutIn(brownoutIn),
    .ctlWr(ctlWr), .ctlWrStandby(ctlWrStandby), .ctlWrDevReset(ctlWrDevReset),
    .ctlWrMode(ctlWrMode), .ctlWrInputPwm(ctlWrInputPwm), .fireWr(fireWr),
    .fireWrData(fireWrData), .seqDone(seqDone), .regAccessEn(regAccessEn),
    .standby(standby), .devReset(devReset), .mode(mode), .inputPwm(inputPwm),
    .fireBit(fireBit), .goSignal(goSignal), .driveEnable(driveEnable),
    .shortCheckEn(shortCheckEn), .overTempFlag(overTempFlag),
    .output_short_flag(output_short_flag),
    .realtime_register_playback(realtime_register_playback), .diagRun(diagRun),
    .calibRun(calibRun), .protoRecover(protoRecover), .powerState(powerState));

  hmpc_link_host i_host (.linkClk(linkClk), .linkBusy(linkBusy),
    .linkByteDone(linkByteDone), .protoRecover(protoRecover));

  // ********
  // clock, timeout and shared tasks
  // ********
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out();
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // note an expected output field
  task automatic chk(input string nm, input int lsb, input logic [3:0] v);
    notes.push_back('{nm, lsb, (lsb == MD) ? 3 : (lsb == PS) ? 2 : 1, v});
    ->look;
  endtask

  task automatic wr_mode(input logic sb, input logic dr, input logic [2:0] md, input logic p);
    @(posedge clk);
    ctlWr <= 1'b1;
    {ctlWrStandby, ctlWrDevReset, ctlWrMode, ctlWrInputPwm} <= {sb, dr, md, p};
    @(posedge clk);
    ctlWr <= 1'b0;
    #1;
  endtask

  task automatic fire(input logic [7:0] d);
    @(posedge clk);
    fireWr <= 1'b1;
    fireWrData <= d;
    @(posedge clk);
    fireWr <= 1'b0;
    #1;
  endtask

  // trigger pin and fault comparators, then wait past the synchroniser
  task automatic pins(input logic t, input logic [3:0] f);
    @(posedge clk);
    trigger_input_pin <= t;
    {overTempIn, outShortIn, regShortIn, brownoutIn} <= f;
    settle(4);
  endtask

  // oldest notes against the outputs whenever a result is flagged
  initial begin
    hmpc_note_t n;
    forever begin
      @(look);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        `CMP(n.nm, n.v, 4'((obs >> n.lsb) & ((19'h1 << n.w) - 19'h1)))
      end
    end
  end

  // ********
  // main sequence
  // ********
  initial begin
    void'($urandom(32'hB28E));
    {srst, enablePin, trigger_input_pin, overTempIn, outShortIn, regShortIn} = 6'b110000;
    {brownoutIn, ctlWr, ctlWrStandby, ctlWrDevReset, ctlWrMode, ctlWrInputPwm} = '0;
    {fireWr, fireWrData, seqDone} = '0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    settle(3);
    chk("standby", SB, 1);
    chk("state", PS, 1);
    wr_mode(0, 0, 0, 0);
    settle(1);
    chk("state", PS, 3);
    fire(8'h01);
    chk("fire", FB, 1);
    @(posedge clk);
    seqDone <= 1'b1;
    @(posedge clk);
    seqDone <= 1'b0;
    settle(1);
    chk("fire", FB, 0);
    fire(8'h01);
    fire(8'($urandom) & 8'hFE);
    settle(1);
    chk("go", GO, 0);
    fire(8'h01);
    wr_mode(1, 0, 0, 0);
    settle(1);
    chk("go", GO, 0);
    wr_mode(0, 0, 3, 1);
    @(posedge clk);
    enablePin <= 1'b0;
    settle(4);
    chk("access", RA, 0);
    chk("state", PS, 0);
    chk("go", GO, 0);
    wr_mode(0, 0, 6, 0);
    settle(1);
    chk("mode", MD, 3);
    @(posedge clk);
    enablePin <= 1'b1;
    settle(6);
    chk("go", GO, 1);
    foreach (codes[i]) begin
      pw = 1'($urandom);
      wr_mode(0, 0, codes[i], pw);
      chk("mode", MD, codes[i]);
      chk("pwm", IP, pw);
      chk("realtime", RT, codes[i] == 3'h5);
      if (codes[i] > 3'h2) begin
        fire(8'h01);
        settle(1);
        chk("go", GO, 1);
        chk("check", SC, 1);
        chk("diag", DG, codes[i] == 3'h6);
        chk("calib", CB, codes[i] == 3'h7);
        fire(8'h00);
        settle(1);
        chk("go", GO, codes[i] == 3'h5 || (codes[i] == 3'h3 && pw));
      end
    end
    wr_mode(0, 0, 1, 0);
    pins(1, 0);
    chk("fire", FB, 1);
    pins(0, 0);
    chk("fire", FB, 1);
    pins(1, 0);
    chk("fire", FB, 0);
    wr_mode(0, 0, 2, 0);
    settle(1);
    chk("fire", FB, 1);
    pins(0, 0);
    chk("fire", FB, 0);
    wr_mode(0, 0, 0, 0);
    pins(0, 4'b0100);
    chk("short", OS, 0);
    wr_mode(0, 0, 5, 0);
    settle(4);
    chk("short", OS, 1);
    chk("go", GO, 0);
    pins(0, 0);
    chk("short", OS, 0);
    wr_mode(0, 0, 5, 0);
    settle(2);
    chk("go", GO, 0);
    wr_mode(0, 0, 0, 0);
    wr_mode(0, 0, 5, 0);
    settle(2);
    chk("go", GO, 1);
    pins(0, 4'b1000);
    chk("hot", OT, 1);
    chk("drive", DE, 0);
    pins(0, 0);
    chk("drive", DE, 1);
    i_host.frame(5, 1'b0);
    chk("recover", PR, 0);
    fork i_host.frame(1, 1'b1); join_none
    settle(45);
    chk("recover", PR, 0);
    settle(9);
    chk("recover", PR, 1);
    settle(8);
    chk("recover", PR, 0);
    wr_mode(1, 0, 5, 0);
    fork i_host.frame(1, 1'b1); join_none
    settle(70);
    chk("recover", PR, 0);
    wr_mode(0, 0, 5, 0);
    for (int k = 0; k < 80 && protoRecover !== 1'b1; k++) settle(1);
    chk("recover", PR, 1);
    settle(8);
    wr_mode(0, 0, 6, 1);
    fire(8'h01);
    wr_mode(0, 1, 0, 0);
    chk("sreset", DV, 1);
    chk("mode", MD, 0);
    chk("fire", FB, 0);
    settle(4);
    chk("sreset", DV, 0);
    for (int k = 0; k < 2; k++) begin
      wr_mode(0, 0, 3, 1);
      pins(0, 4'b0001 << k);
      chk("state", PS, 2);
      chk("go", GO, 0);
      pins(0, 0);
      chk("mode", MD, 0);
      chk("standby", SB, 1);
    end
    settle(2);
    close_out();
  end
endmodule

`default_nettype wire
